/* File: pkg/wvp_pkg.sv */
// wvp_pkg: constants, field layouts and carriers for the wide vector prefix decoder
package wvp_pkg;
    // register set geometry
    localparam int WVP_VEC_W = 256;           // wide vector register width
    localparam int WVP_NARROW_W = 128;        // narrow register width, aliased low half
    localparam int WVP_NREG = 16;             // registers reachable in 64-bit mode
    localparam int WVP_IDX_W = 4;             // register number width
    // lead bytes of the two prefix forms (plain defaults)
    localparam logic [7:0] WVP_LEAD_2B = 8'hC5;
    localparam logic [7:0] WVP_LEAD_3B = 8'hC4;
    // field positions inside the prefix payload bytes (R, X, B and vvvv are stored inverted)
    localparam int WVP_POS_R = 7;
    localparam int WVP_POS_X = 6;
    localparam int WVP_POS_B = 5;
    localparam int WVP_MAP_HI = 4;
    localparam int WVP_MAP_LO = 0;
    localparam int WVP_POS_W = 7;
    localparam int WVP_VVVV_HI = 6;
    localparam int WVP_VVVV_LO = 3;
    localparam int WVP_POS_L = 2;
    localparam int WVP_PP_HI = 1;
    localparam int WVP_PP_LO = 0;
    localparam int WVP_IS4_HI = 7;            // third source in upper immediate bits
    localparam int WVP_IS4_LO = 4;
    // compact escape field codes
    localparam logic [4:0] WVP_MAP_0F = 5'h01;
    localparam logic [4:0] WVP_MAP_0F38 = 5'h02;
    localparam logic [4:0] WVP_MAP_0F3A = 5'h03;
    // memory operand alignment masks on the low address bits
    localparam logic [4:0] WVP_ALIGN16_MASK = 5'h0F;
    localparam logic [4:0] WVP_ALIGN32_MASK = 5'h1F;
    localparam logic [1:0] WVP_MOD_REG = 2'h3;   // modrm mod value for register operand

    // inferred escape sequence, one-hot
    typedef enum logic [3:0] {
        WVP_ESC_NONE = 4'h1,
        WVP_ESC_0F = 4'h2,
        WVP_ESC_0F38 = 4'h4,
        WVP_ESC_0F3A = 4'h8
    } wvp_esc_t;
    // implied legacy opcode-extension prefix
    typedef enum logic [1:0] {
        WVP_OPX_NONE = 2'h0,
        WVP_OPX_66 = 2'h1,
        WVP_OPX_F3 = 2'h2,
        WVP_OPX_F2 = 2'h3
    } wvp_opx_t;

    // one instruction from the fetch stream
    typedef struct packed {
        logic valid;
        logic [7:0] lead;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] opcode;
        logic [7:0] modrm;
        logic [7:0] imm8;
        logic [4:0] addr_lo;
    } wvp_req_t;
    // opcode table class of the same instruction
    typedef struct packed {
        logic defined;        // prefix is defined on this opcode
        logic legacy_regs;    // opcode works on packed-integer or fp stack regs
        logic four_op;        // third source in immediate
        logic allow_l256;     // 256-bit length permitted
        logic align_strict;   // prefixed form still needs alignment
        logic legacy_align;   // unprefixed form needs alignment
        logic gpr_operand;    // one operand is a general-purpose register
    } wvp_cls_t;
    // raw fields recovered from the prefix
    typedef struct packed {
        logic present;
        logic r;
        logic x;
        logic b;
        logic w;
        logic l;
        logic [4:0] map;
        logic [3:0] vvvv;
        logic [1:0] pp;
    } wvp_fields_t;
    // decoded instruction
    typedef struct packed {
        logic valid;
        logic invalid;
        logic prefixed;
        logic vl256;
        logic w;
        logic four_op;
        logic gpr_operand;
        logic align_fault;
        wvp_esc_t esc;
        wvp_opx_t opx;
        logic [3:0] dst;
        logic [3:0] src1;
        logic [3:0] src2;
        logic [3:0] src3;
        logic [2:0] idx_x;
    } wvp_dec_t;
    // writeback into the register set
    typedef struct packed {
        logic valid;
        logic prefixed;
        logic vl256;
        logic [3:0] idx;
        logic [255:0] data;
    } wvp_wb_t;

    // compact escape field to escape sequence
    function automatic wvp_esc_t wvp_esc_of(input logic [4:0] map);
        case (map)
            WVP_MAP_0F: wvp_esc_of = WVP_ESC_0F;
            WVP_MAP_0F38: wvp_esc_of = WVP_ESC_0F38;
            WVP_MAP_0F3A: wvp_esc_of = WVP_ESC_0F3A;
            default: wvp_esc_of = WVP_ESC_NONE;
        endcase
    endfunction : wvp_esc_of

    // register number limited to eight registers outside 64-bit mode
    function automatic logic [3:0] wvp_reg_idx(input logic [3:0] idx, input logic mode64);
        wvp_reg_idx = mode64 ? idx : {1'b0, idx[2:0]};
    endfunction : wvp_reg_idx
endpackage : wvp_pkg

/* File: core/wvp_field_split.sv */
// wvp_field_split: recovers the compact fields from either prefix form
`timescale 1ns/10ps
`default_nettype none
module wvp_field_split
    import wvp_pkg::*;
(
    // prefix bytes
    input wire logic [7:0] lead_in,
    input wire logic [7:0] b1_in,
    input wire logic [7:0] b2_in,
    // recovered fields
    output var wvp_fields_t fld_out
);
    // stored bits are inverted so that an all-ones byte means no extension
    always_comb begin
        fld_out = '0;
        if (lead_in == WVP_LEAD_2B) begin
            // short form: escape implied, index and base extension absent
            fld_out.present = 1'b1;
            fld_out.r = ~b1_in[WVP_POS_R];
            fld_out.vvvv = ~b1_in[WVP_VVVV_HI:WVP_VVVV_LO];
            fld_out.l = b1_in[WVP_POS_L];
            fld_out.pp = b1_in[WVP_PP_HI:WVP_PP_LO];
            fld_out.map = WVP_MAP_0F;
        end else if (lead_in == WVP_LEAD_3B) begin
            // long form: full extension bits and escape field
            fld_out.present = 1'b1;
            fld_out.r = ~b1_in[WVP_POS_R];
            fld_out.x = ~b1_in[WVP_POS_X];
            fld_out.b = ~b1_in[WVP_POS_B];
            fld_out.map = b1_in[WVP_MAP_HI:WVP_MAP_LO];
            fld_out.w = b2_in[WVP_POS_W];
            fld_out.vvvv = ~b2_in[WVP_VVVV_HI:WVP_VVVV_LO];
            fld_out.l = b2_in[WVP_POS_L];
            fld_out.pp = b2_in[WVP_PP_HI:WVP_PP_LO];
        end
    end
endmodule : wvp_field_split
`default_nettype wire

/* File: core/wvp_regfile.sv */
// wvp_regfile: wide vector registers with the narrow names aliased on the low half
`timescale 1ns/10ps
`default_nettype none
module wvp_regfile
    import wvp_pkg::*;
#(
    parameter int NREG = WVP_NREG,
    parameter int VW = WVP_VEC_W,
    parameter int NW = WVP_NARROW_W
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // writeback
    input wire wvp_wb_t wb_in,
    // read port
    input wire logic [3:0] rd_idx_in,
    output logic [VW-1:0] rd_wide_out,
    output logic [NW-1:0] rd_narrow_out
);
    logic [VW-1:0] regs_ff [NREG];   // one storage, two names
    logic [VW-1:0] nxt_regs [NREG];
    logic [VW-1:0] rd_ff;
    logic [VW-1:0] nxt_rd;

    // merge of a write by kind; the narrow name is just the low half
    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            nxt_regs[i] = regs_ff[i];
        end
        if (wb_in.valid) begin
            if (!wb_in.prefixed) begin
                nxt_regs[wb_in.idx][NW-1:0] = wb_in.data[NW-1:0];
            end else if (wb_in.vl256) begin
                nxt_regs[wb_in.idx] = wb_in.data;
            end else begin
                nxt_regs[wb_in.idx] = {{(VW-NW){1'b0}}, wb_in.data[NW-1:0]};
            end
        end
        nxt_rd = regs_ff[rd_idx_in];
    end

    // storage and read register
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < NREG; i++) begin
                regs_ff[i] <= '0;
            end
            rd_ff <= '0;
        end else begin
            regs_ff <= nxt_regs;
            rd_ff <= nxt_rd;
        end
    end

    assign rd_wide_out = rd_ff;
    assign rd_narrow_out = rd_ff[NW-1:0];

    // narrow view checked against the stored low half, not against the wide output
    a_alias_low: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        rd_narrow_out == $past(regs_ff[rd_idx_in][NW-1:0]))
        else $error("narrow view differs");
    a_legacy_upper: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        wb_in.valid && !wb_in.prefixed |=>
        regs_ff[$past(wb_in.idx)][VW-1:NW] == $past(regs_ff[wb_in.idx][VW-1:NW]))
        else $error("legacy write touched upper half");
    a_zero_upper: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        wb_in.valid && wb_in.prefixed && !wb_in.vl256 |=>
        regs_ff[$past(wb_in.idx)][VW-1:NW] == '0) else $error("upper half not zeroed");
endmodule : wvp_regfile
`default_nettype wire

/* File: core/wvp_decode_top.sv */
// wvp_decode_top: prefix decode of one instruction per cycle plus the wide register set
`timescale 1ns/10ps
`default_nettype none
module wvp_decode_top
    import wvp_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // operating mode
    input wire logic mode64_in,
    // instruction from the front end, with its opcode table class
    input wire wvp_req_t req_in,
    input wire wvp_cls_t cls_in,
    // decoded instruction, one cycle later
    output var wvp_dec_t dec_out,
    // writeback from execution
    input wire wvp_wb_t wb_in,
    // register read
    input wire logic [3:0] rd_idx_in,
    output logic [WVP_VEC_W-1:0] rd_wide_out,
    output logic [WVP_NARROW_W-1:0] rd_narrow_out
);
    wvp_fields_t fld;            // raw prefix fields
    wvp_dec_t dec_ff;            // registered decode
    wvp_dec_t nxt_dec;           // next decode
    wvp_wb_t wb_lim;             // writeback limited to the mode's register count
    logic mem_op;                // modrm names a memory operand
    logic need_align;            // this form demands natural alignment
    logic [4:0] align_mask;      // low address bits that must be zero

    // field recovery is shared logic, kept apart so both prefix forms stay in one place
    wvp_field_split u_split (
        .lead_in(req_in.lead),
        .b1_in(req_in.b1),
        .b2_in(req_in.b2),
        .fld_out(fld)
    );

    // decode of operands, extensions and validity
    always_comb begin
        nxt_dec = '0;
        mem_op = req_in.modrm[7:6] != WVP_MOD_REG;
        need_align = 1'b0;
        align_mask = WVP_ALIGN16_MASK;
        nxt_dec.valid = req_in.valid;
        nxt_dec.prefixed = fld.present;
        nxt_dec.gpr_operand = cls_in.gpr_operand;
        if (fld.present) begin
            // register extension taken from the prefix, no extra byte needed
            nxt_dec.dst = wvp_reg_idx({fld.r, req_in.modrm[5:3]}, mode64_in);
            nxt_dec.src2 = wvp_reg_idx({fld.b, req_in.modrm[2:0]}, mode64_in);
            nxt_dec.idx_x = {fld.x, 2'b00};
            nxt_dec.w = fld.w;
            // extra source named inside the prefix, destination left distinct
            nxt_dec.src1 = wvp_reg_idx(fld.vvvv, mode64_in);
            // escape bytes and opcode extension inferred from compact fields
            nxt_dec.esc = wvp_esc_of(fld.map);
            nxt_dec.opx = wvp_opx_t'(fld.pp);
            nxt_dec.vl256 = fld.l;
            nxt_dec.four_op = cls_in.four_op;
            if (cls_in.four_op) begin
                // third source sits in the immediate's upper nibble
                nxt_dec.src3 = wvp_reg_idx(req_in.imm8[WVP_IS4_HI:WVP_IS4_LO],
                    mode64_in);
            end
            // prefix refused on undefined, old register file or bad length
            nxt_dec.invalid = !cls_in.defined
                || cls_in.legacy_regs
                || (nxt_dec.esc == WVP_ESC_NONE)
                || (fld.l && !cls_in.allow_l256);
            // relaxed alignment unless the opcode is one of the strict few
            need_align = mem_op && cls_in.align_strict;
            align_mask = fld.l ? WVP_ALIGN32_MASK : WVP_ALIGN16_MASK;
        end else begin
            // unprefixed: two-operand form, destination is also first source
            nxt_dec.dst = wvp_reg_idx({1'b0, req_in.modrm[5:3]}, mode64_in);
            nxt_dec.src1 = nxt_dec.dst;
            nxt_dec.src2 = wvp_reg_idx({1'b0, req_in.modrm[2:0]}, mode64_in);
            nxt_dec.esc = WVP_ESC_NONE;
            nxt_dec.opx = WVP_OPX_NONE;
            need_align = mem_op && cls_in.legacy_align;
        end
        nxt_dec.align_fault = need_align && ((req_in.addr_lo & align_mask) != 5'h00);
        if (!req_in.valid) begin
            // keep an idle slot clean so nothing downstream acts on stale fields
            nxt_dec = '0;
        end
    end

    // decode stage register
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            dec_ff <= '0;
        end else begin
            dec_ff <= nxt_dec;
        end
    end

    assign dec_out = dec_ff;

    // writeback index limited outside 64-bit mode so the upper eight never change there
    always_comb begin
        wb_lim = wb_in;
        wb_lim.idx = wvp_reg_idx(wb_in.idx, mode64_in);
    end

    // storage and aliasing
    wvp_regfile #(
        .NREG(WVP_NREG),
        .VW(WVP_VEC_W),
        .NW(WVP_NARROW_W)
    ) u_regs (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .wb_in(wb_lim),
        .rd_idx_in(wvp_reg_idx(rd_idx_in, mode64_in)),
        .rd_wide_out(rd_wide_out),
        .rd_narrow_out(rd_narrow_out)
    );

    // checks on the decode stage
    a_reg_count: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !$past(mode64_in) |-> !dec_out.dst[3] && !dec_out.src1[3] && !dec_out.src2[3])
        else $error("upper registers named outside 64-bit mode");
    a_ndsrc_field: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $past(req_in.valid) && $past(req_in.lead) == WVP_LEAD_2B && $past(mode64_in)
        |-> dec_out.src1 == ~$past(req_in.b1[WVP_VVVV_HI:WVP_VVVV_LO]))
        else $error("prefix source register wrong");
    a_is4_field: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        dec_out.valid && dec_out.prefixed && dec_out.four_op && $past(mode64_in)
        |-> dec_out.src3 == $past(req_in.imm8[WVP_IS4_HI:WVP_IS4_LO]))
        else $error("third source not from immediate");
    a_regext_field: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $past(req_in.valid) && $past(req_in.lead) == WVP_LEAD_3B && $past(mode64_in)
        |-> dec_out.dst[3] == !$past(req_in.b1[WVP_POS_R])
            && dec_out.src2[3] == !$past(req_in.b1[WVP_POS_B]))
        else $error("register extension wrong");
    a_opx_compact: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $past(req_in.valid) && $past(req_in.lead) == WVP_LEAD_2B
        |-> dec_out.opx == wvp_opx_t'($past(req_in.b1[WVP_PP_HI:WVP_PP_LO])))
        else $error("opcode extension wrong");
    a_map_infer: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $past(req_in.valid) && $past(req_in.lead) == WVP_LEAD_3B
        && $past(req_in.b1[WVP_MAP_HI:WVP_MAP_LO]) == WVP_MAP_0F38
        |-> dec_out.esc == WVP_ESC_0F38) else $error("escape not inferred");
    a_len_select: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $past(req_in.valid) && $past(req_in.lead) == WVP_LEAD_2B
        |-> dec_out.vl256 == $past(req_in.b1[WVP_POS_L])) else $error("length wrong");
    a_old_regs: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $past(req_in.valid) && $past(fld.present) && $past(cls_in.legacy_regs)
        |-> dec_out.invalid) else $error("prefix accepted on old register file");
    a_align_relax: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $past(req_in.valid) && $past(fld.present) && !$past(cls_in.align_strict)
        |-> !dec_out.align_fault) else $error("relaxed form faulted");
    a_undef_flag: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $past(req_in.valid) && $past(fld.present) && !$past(cls_in.defined)
        |-> dec_out.invalid && dec_out.valid) else $error("undefined opcode not flagged");
    a_legacy_pass: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $past(req_in.valid) && !$past(fld.present) |-> !dec_out.invalid
        && dec_out.src1 == dec_out.dst) else $error("unprefixed decode wrong");

    // main scenarios
    c_three_op: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        dec_out.valid && dec_out.prefixed && !dec_out.invalid && dec_out.src1 != dec_out.dst);
    c_four_op: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        dec_out.valid && dec_out.four_op && !dec_out.invalid);
    c_long_vec: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        dec_out.valid && dec_out.vl256 && !dec_out.invalid);
    c_rejected: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        dec_out.valid && dec_out.invalid);
endmodule : wvp_decode_top
`default_nettype wire

/* File: verification/wvp_fetch_model.sv */
// wvp_fetch_model: front-end fetch stream handing one instruction at a time to the decoder
`timescale 1ns/10ps
`default_nettype none
module wvp_fetch_model
    import wvp_pkg::*;
(
    // clock
    input wire logic clk_in,
    // instruction and its opcode class toward the decoder
    output var wvp_req_t req_out,
    output var wvp_cls_t cls_out
);
    // idle word: valid low, other fields flipped so a stale value never looks current
    wvp_req_t idle_w;

    // quiet stream until the first instruction
    initial begin
        req_out = '0;
        cls_out = '0;
    end

    // present one instruction for exactly one clock, then fall back to idle
    task automatic issue(input wvp_req_t r, input wvp_cls_t c);
        @(posedge clk_in);
        #1;
        req_out = r;
        cls_out = c;
        @(posedge clk_in);
        #1;
        idle_w = ~r;
        idle_w.valid = 1'b0;
        req_out = idle_w;
        cls_out = ~c;
    endtask : issue
endmodule : wvp_fetch_model
`default_nettype wire

/* File: verification/test_wvp_decode_top.sv */
// test_wvp_decode_top: self-checking bench for prefix decode and the wide register set
`timescale 1ns/10ps
`default_nettype none
module test_wvp_decode_top;
    import wvp_pkg::*;
    // clock, reset, mode
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic mode64_in = 1'b1;
    // decode path
    wvp_req_t req;
    wvp_cls_t cls;
    wvp_dec_t dec_out;
    // register path
    wvp_wb_t wb_in = '0;
    logic [3:0] rd_idx_in = 4'h0;
    logic [255:0] rd_wide_out;
    logic [127:0] rd_narrow_out;
    // bookkeeping
    int mismatches = 0;
    int n_tests = 0;
    // expected tables for pp and map fields
    wvp_opx_t opx_tab [4] = '{WVP_OPX_NONE, WVP_OPX_66, WVP_OPX_F3, WVP_OPX_F2};
    wvp_esc_t esc_tab [4] = '{WVP_ESC_NONE, WVP_ESC_0F, WVP_ESC_0F38, WVP_ESC_0F3A};
    localparam logic [255:0] D1 = {8{32'hA5C3_0F1E}};
    localparam logic [255:0] D2 = {8{32'h1234_BEEF}};
    localparam logic [255:0] D3 = {8{32'h5A5A_7E81}};

    always #20 clk_in = ~clk_in;

    wvp_decode_top wvp_decode_top_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .mode64_in(mode64_in), .req_in(req), .cls_in(cls), .dec_out(dec_out), .wb_in(wb_in),
        .rd_idx_in(rd_idx_in), .rd_wide_out(rd_wide_out), .rd_narrow_out(rd_narrow_out));
    wvp_fetch_model wvp_fetch_model_i (.clk_in(clk_in), .req_out(req), .cls_out(cls));

    // compare tasks, one per kind of result
    task automatic chk_dec(input wvp_dec_t got, input wvp_dec_t exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: decode got %h expected %h", $time, got, exp);
        end
    endtask : chk_dec
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: flag got %b expected %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_vec(input logic [255:0] got, input logic [255:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: register got %h expected %h", $time, got, exp);
        end
    endtask : chk_vec

    // stimulus builders
    function automatic wvp_req_t mk_req(input logic [7:0] lead, b1, b2, modrm, imm8,
                                        input logic [4:0] addr);
        return '{1'b1, lead, b1, b2, 8'h58, modrm, imm8, addr};
    endfunction : mk_req
    function automatic wvp_cls_t mk_cls(input logic def, leg, four, l256, strict, lal);
        return '{def, leg, four, l256, strict, lal, 1'b0};
    endfunction : mk_cls
    function automatic wvp_dec_t dexp(input logic pref, vl, w, four, input wvp_esc_t esc,
        input wvp_opx_t opx, input logic [3:0] dst, s1, s2, s3, input logic [2:0] ix);
        return '{1'b1, 1'b0, pref, vl, w, four, 1'b0, 1'b0, esc, opx, dst, s1, s2, s3, ix};
    endfunction : dexp

    // one writeback, taken at the next edge
    task automatic wr(input logic pref, vl, input logic [3:0] idx, input logic [255:0] d);
        @(posedge clk_in);
        #1;
        wb_in = '{1'b1, pref, vl, idx, d};
        @(posedge clk_in);
        #1;
        wb_in = '{1'b0, ~pref, ~vl, ~idx, ~d};
    endtask : wr
    // present a read index and check both views one edge later
    task automatic rd_chk(input logic [3:0] idx, input logic [255:0] exp);
        rd_idx_in = idx;
        @(posedge clk_in);
        #1;
        chk_vec(rd_wide_out, exp);
        chk_vec({128'h0, rd_narrow_out}, {128'h0, exp[127:0]});
    endtask : rd_chk

    // short form: fields, length, pp, escape, register extension
    task automatic t_two_byte();
        for (int p = 0; p < 4; p++) begin
            wvp_fetch_model_i.issue(mk_req(WVP_LEAD_2B, {1'b0, 4'h8, 1'b0, p[1:0]}, 8'hFF,
                8'hD1, 8'hF0, 5'h00), mk_cls(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
            chk_dec(dec_out, dexp(1'b1, 1'b0, 1'b0, 1'b0, WVP_ESC_0F, opx_tab[p], 4'hA,
                4'h7, 4'h1, 4'h0, 3'h0));
        end
        $display("test two_byte done");
    endtask : t_two_byte

    // long form: every escape code, 256-bit length, immediate third source
    task automatic t_three_byte();
        for (int m = 0; m < 4; m++) begin
            wvp_fetch_model_i.issue(mk_req(WVP_LEAD_3B, {3'b100, m[4:0]}, 8'hE5, 8'hC6,
                8'h7E, 5'h00), mk_cls(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0));
            if (m == 0) chk_bit(dec_out.invalid, 1'b1);
            else chk_dec(dec_out, dexp(1'b1, 1'b1, 1'b1, 1'b1, esc_tab[m], WVP_OPX_66,
                4'h0, 4'h3, 4'hE, 4'h7, 3'h4));
        end
        $display("test three_byte done");
    endtask : t_three_byte

    // refusals: undefined, legacy register opcodes, forbidden length; unprefixed untouched
    task automatic t_refuse();
        wvp_cls_t c [4];
        c = '{mk_cls(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0),
              mk_cls(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0),
              mk_cls(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0),
              mk_cls(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0)};
        for (int k = 0; k < 4; k++) begin
            wvp_fetch_model_i.issue(mk_req(WVP_LEAD_2B, 8'hFC, 8'h00, 8'hD1, 8'h00, 5'h00), c[k]);
            chk_bit(dec_out.invalid, k != 3);
            chk_bit(dec_out.valid, 1'b1);
        end
        wvp_fetch_model_i.issue(mk_req(8'h0F, 8'h00, 8'h00, 8'hD1, 8'h00, 5'h00),
            mk_cls(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
        chk_dec(dec_out, dexp(1'b0, 1'b0, 1'b0, 1'b0, WVP_ESC_NONE, WVP_OPX_NONE, 4'h2,
            4'h2, 4'h1, 4'h0, 3'h0));
        $display("test refuse done");
    endtask : t_refuse

    // memory operand alignment for prefixed and unprefixed forms
    task automatic t_align();
        logic [7:0] ld [4] = '{WVP_LEAD_2B, WVP_LEAD_2B, WVP_LEAD_2B, 8'h0F};
        logic lb [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        logic st [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        logic ex [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        for (int k = 0; k < 4; k++) begin
            wvp_fetch_model_i.issue(mk_req(ld[k], {1'b1, 4'hF, lb[k], 2'b00}, 8'h00, 8'h11,
                8'h00, (k == 3) ? 5'h08 : 5'h10),
                mk_cls(1'b1, 1'b0, 1'b0, 1'b1, st[k], 1'b1));
            chk_bit(dec_out.align_fault, ex[k]);
        end
        $display("test align done");
    endtask : t_align

    // outside 64-bit mode only eight registers are reachable
    task automatic t_mode32();
        wvp_cls_t c;
        wvp_dec_t e;
        mode64_in = 1'b0;
        // a general-purpose operand class rides along to the decoded word
        c = mk_cls(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        c.gpr_operand = 1'b1;
        e = dexp(1'b1, 1'b0, 1'b0, 1'b0, WVP_ESC_0F, WVP_OPX_NONE, 4'h2, 4'h7,
            4'h1, 4'h0, 3'h0);
        e.gpr_operand = 1'b1;
        wvp_fetch_model_i.issue(mk_req(WVP_LEAD_2B, 8'h40, 8'h00, 8'hD1, 8'h00, 5'h00), c);
        chk_dec(dec_out, e);
        // writeback and read index both lose bit 3, so index B lands in register 3
        wr(1'b1, 1'b1, 4'hB, D2);
        rd_chk(4'h3, D2);
        mode64_in = 1'b1;
        $display("test mode32 done");
    endtask : t_mode32

    // upper half kept by unprefixed writes, cleared by prefixed 128-bit writes
    task automatic t_regs();
        wr(1'b1, 1'b1, 4'h9, D1);
        rd_chk(4'h9, D1);
        wr(1'b0, 1'b0, 4'h9, D2);
        rd_chk(4'h9, {D1[255:128], D2[127:0]});
        wr(1'b1, 1'b0, 4'h9, D3);
        rd_chk(4'h9, {128'h0, D3[127:0]});
        $display("test regs done");
    endtask : t_regs

    // verdict and end of run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    // main sequence
    initial begin
        repeat (8) @(posedge clk_in);
        #1;
        rst_b_in = 1'b1;
        chk_dec(dec_out, '0);
        chk_vec(rd_wide_out, '0);
        t_two_byte();
        t_three_byte();
        t_refuse();
        t_align();
        t_mode32();
        t_regs();
        stop_test();
    end

    // watchdog: the tests need well under a hundred cycles
    initial begin
        #(40 * 2000);
        mismatches++;
        stop_test();
    end
endmodule : test_wvp_decode_top
`default_nettype wire
